// ===== design/pressure_flow_status_inputs.sv
// Read-only measurement and status input register bank
// What this block does
// - With a fan constant set, volume flow is that constant times the root of the pressure.
// - Without a fan constant, flow is duct area times velocity, which needs velocity enabled.
// - Air velocity is updated only while velocity is enabled, clamped to 0..150.
// - Output percentage is shown in tenths of a percent, clamped to 0..1000.
// - A flow maximum register is derived from the selected fan constant or duct area.
// - The span flag is 1 when pressure, volume or, while velocity is enabled, velocity lies outside its span limits.
// - The alarm flag is 1 when pressure, volume or, while velocity is enabled, velocity lies outside its alarm limits.
// - Both flags are held at 0 while automatic tuning runs.
// - The feedback-lost register reads 1 when pressure feedback is lost, else 0.
// - The sensor-fault register reads 1 when the sensing element has failed, else 0.
// - The red indicator flashes while feedback is lost or the sensor has failed.
// - Flow and flow maximum are in whole cubic metres per hour.
`timescale 1ns/1ps
module pressure_flow_status_inputs #(
  parameter int FLASH_HALF_CYCLES = flow_status_pkg::FLASH_HALF_CYCLES
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               reset_n,
  // Measurement samples from the control loop
  input  wire logic               sampleStrobe,
  input  wire logic signed [15:0] pressureIn,
  input  wire logic [15:0]        velocityIn,
  input  wire logic [15:0]        outputIn,
  // Flow configuration
  input  wire logic [15:0]        fanConstant,
  input  wire logic [15:0]        ductArea,
  input  wire logic               velocityEnable,
  // Span limits
  input  wire logic signed [15:0] spanPressMin,
  input  wire logic signed [15:0] spanPressMax,
  input  wire logic [15:0]        spanVolMin,
  input  wire logic [15:0]        spanVolMax,
  input  wire logic [15:0]        spanVelMin,
  input  wire logic [15:0]        spanVelMax,
  // Alarm limits
  input  wire logic signed [15:0] alarmPressMin,
  input  wire logic signed [15:0] alarmPressMax,
  input  wire logic [15:0]        alarmVolMin,
  input  wire logic [15:0]        alarmVolMax,
  input  wire logic [15:0]        alarmVelMin,
  input  wire logic [15:0]        alarmVelMax,
  // Status conditions
  input  wire logic               autoTune,
  input  wire logic               feedbackLostIn,
  input  wire logic               sensorFaultIn,
  // Register read port
  input  wire logic               readStrobe,
  input  wire logic [15:0]        readAddr,
  output logic [15:0]             readData_q,
  output logic                    readValid_q,
  // Red indicator
  output logic                    ledRed_q
);

  // Helpers
  function automatic logic signed [16:0] sx(input logic [15:0] v);
    sx = $signed({v[15], v});
  endfunction

  function automatic logic signed [16:0] zx(input logic [15:0] v);
    zx = $signed({1'b0, v});
  endfunction

  function automatic logic outside(input logic signed [16:0] v,
                                   input logic signed [16:0] lo,
                                   input logic signed [16:0] hi);
    outside = (v < lo) || (v > hi);
  endfunction

  function automatic logic [15:0] satFlow(input logic [39:0] v);
    satFlow = (v > {24'h000000, flow_status_pkg::FLOW_SAT}) ?
              flow_status_pkg::FLOW_SAT : v[15:0];
  endfunction

  function automatic logic [15:0] areaFlow(input logic [15:0] area,
                                           input logic [15:0] vel);
    logic [39:0] prod;
    prod = {24'h000000, area} * {24'h000000, vel};
    areaFlow = satFlow((prod * flow_status_pkg::FLOW_AREA_NUM) /
                       flow_status_pkg::FLOW_AREA_DEN);
  endfunction

  // Register contents
  logic signed [15:0] pressure_q;
  logic [15:0]        flow_q;
  logic [15:0]        velocity_q;
  logic [15:0]        output_q;
  logic [15:0]        flowMax_q;
  logic               spanFlag_q;
  logic               alarmFlag_q;
  logic               feedbackLost_q;
  logic               sensorFault_q;
  logic               sqrtStart_q;
  logic [15:0]        radicand_q;
  logic               tick;
  logic               faultAny;

  // Sample conditioning
  logic signed [15:0] pressureClamp;
  logic [15:0]        velocityClamp;
  logic [15:0]        outputClamp;
  logic [15:0]        velocityNext;
  flow_status_pkg::flow_mode_t flowMode;

  // Limit comparisons
  logic spanP, spanV, spanVel;
  logic alarmP, alarmV, alarmVel;

  sqrt_if sqrtBus ();

  sqrt_engine u_sqrt (
    .clk     (clk),
    .reset_n (reset_n),
    .bus     (sqrtBus.engine)
  );

  blink_divider #(
    .HALF_CYCLES (FLASH_HALF_CYCLES)
  ) u_blink (
    .clk     (clk),
    .reset_n (reset_n),
    .tick_q  (tick)
  );

  assign sqrtBus.start    = sqrtStart_q;
  assign sqrtBus.radicand = radicand_q;

  always_comb begin
    if (pressureIn > flow_status_pkg::PRESSURE_MAX) begin
      pressureClamp = flow_status_pkg::PRESSURE_MAX;
    end else if (pressureIn < flow_status_pkg::PRESSURE_MIN) begin
      pressureClamp = flow_status_pkg::PRESSURE_MIN;
    end else begin
      pressureClamp = pressureIn;
    end
    velocityClamp = (velocityIn > flow_status_pkg::VELOCITY_MAX) ?
                    flow_status_pkg::VELOCITY_MAX : velocityIn;
    outputClamp   = (outputIn > flow_status_pkg::OUTPUT_MAX) ?
                    flow_status_pkg::OUTPUT_MAX : outputIn;
    velocityNext  = velocityEnable ? velocityClamp : velocity_q;
  end

  // Fan constant wins, duct area needs velocity enabled
  always_comb begin
    if (fanConstant != flow_status_pkg::REG_ZERO) begin
      flowMode = flow_status_pkg::MODE_K;
    end else if (velocityEnable) begin
      flowMode = flow_status_pkg::MODE_AREA;
    end else begin
      flowMode = flow_status_pkg::MODE_NONE;
    end
  end

  // Measurement capture
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pressure_q  <= 16'sh0000;
      velocity_q  <= 16'h0000;
      output_q    <= 16'h0000;
      sqrtStart_q <= 1'b0;
      radicand_q  <= 16'h0000;
    end else begin
      sqrtStart_q <= 1'b0;
      if (sampleStrobe) begin
        pressure_q  <= pressureClamp;
        output_q    <= outputClamp;
        velocity_q  <= velocityNext;
        sqrtStart_q <= 1'b1;
        radicand_q  <= pressureClamp[15] ? 16'h0000 : pressureClamp;
      end
    end
  end

  // Volume flow
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      flow_q <= 16'h0000;
    end else begin
      case (flowMode)
        flow_status_pkg::MODE_K: begin
          if (sqrtBus.done) begin
            flow_q <= satFlow({24'h000000, fanConstant} * {32'h00000000, sqrtBus.root});
          end
        end
        flow_status_pkg::MODE_AREA: begin
          if (sampleStrobe) flow_q <= areaFlow(ductArea, velocityNext);
        end
        default: begin
          if (sampleStrobe) flow_q <= flow_status_pkg::REG_ZERO;
        end
      endcase
    end
  end

  // Largest achievable flow
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      flowMax_q <= 16'h0000;
    end else begin
      case (flowMode)
        flow_status_pkg::MODE_K:
          flowMax_q <= satFlow({24'h000000, fanConstant} *
                               {24'h000000, flow_status_pkg::SQRT_PRESSURE_MAX});
        flow_status_pkg::MODE_AREA:
          flowMax_q <= areaFlow(ductArea, flow_status_pkg::VELOCITY_MAX);
        default:
          flowMax_q <= flow_status_pkg::REG_ZERO;
      endcase
    end
  end

  // Span and alarm comparisons, velocity only while it is measured
  always_comb begin
    spanP    = outside(sx(pressure_q), sx(spanPressMin), sx(spanPressMax));
    spanV    = outside(zx(flow_q), zx(spanVolMin), zx(spanVolMax));
    spanVel  = velocityEnable && outside(zx(velocity_q), zx(spanVelMin), zx(spanVelMax));
    alarmP   = outside(sx(pressure_q), sx(alarmPressMin), sx(alarmPressMax));
    alarmV   = outside(zx(flow_q), zx(alarmVolMin), zx(alarmVolMax));
    alarmVel = velocityEnable && outside(zx(velocity_q), zx(alarmVelMin), zx(alarmVelMax));
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      spanFlag_q  <= 1'b0;
      alarmFlag_q <= 1'b0;
    end else begin
      spanFlag_q  <= !autoTune && (spanP || spanV || spanVel);
      alarmFlag_q <= !autoTune && (alarmP || alarmV || alarmVel);
    end
  end

  // Fault conditions
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      feedbackLost_q <= 1'b0;
      sensorFault_q  <= 1'b0;
    end else begin
      feedbackLost_q <= feedbackLostIn;
      sensorFault_q  <= sensorFaultIn;
    end
  end

  assign faultAny = feedbackLost_q || sensorFault_q;

  // Red indicator toggles each half period while a fault stands
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ledRed_q <= 1'b0;
    end else if (!faultAny) begin
      ledRed_q <= 1'b0;
    end else if (tick) begin
      ledRed_q <= !ledRed_q;
    end
  end

  // Read port, no side effects on any register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      readData_q  <= 16'h0000;
      readValid_q <= 1'b0;
    end else begin
      readValid_q <= readStrobe;
      if (readStrobe) begin
        case (readAddr)
          flow_status_pkg::REG_PRESSURE: readData_q <= pressure_q;
          flow_status_pkg::REG_FLOW:     readData_q <= flow_q;
          flow_status_pkg::REG_VELOCITY: readData_q <= velocity_q;
          flow_status_pkg::REG_OUTPUT:   readData_q <= output_q;
          flow_status_pkg::REG_FLOW_MAX: readData_q <= flowMax_q;
          flow_status_pkg::REG_SPAN:     readData_q <= {15'h0000, spanFlag_q};
          flow_status_pkg::REG_ALARM:    readData_q <= {15'h0000, alarmFlag_q};
          flow_status_pkg::REG_FB_LOST:  readData_q <= {15'h0000, feedbackLost_q};
          flow_status_pkg::REG_SENSOR:   readData_q <= {15'h0000, sensorFault_q};
          default:                       readData_q <= flow_status_pkg::REG_ZERO;
        endcase
      end
    end
  end

  // Checks
  logic rsvdAddr;
  assign rsvdAddr = (readAddr == flow_status_pkg::REG_RSVD_TWO) ||
                    (readAddr == flow_status_pkg::REG_RSVD_SIX) ||
                    ((readAddr >= flow_status_pkg::REG_RSVD_FIRST) &&
                     (readAddr <= flow_status_pkg::REG_RSVD_LAST));

  sequence s_sampleK;
    sampleStrobe && !pressureClamp[15] && flowMode == flow_status_pkg::MODE_K;
  endsequence

  sequence s_rootReady;
    sqrtBus.done && flowMode == flow_status_pkg::MODE_K;
  endsequence

  property p_flowK;
    @(posedge clk) disable iff (!reset_n)
      s_rootReady |=> flow_q == satFlow({24'h000000, $past(fanConstant)} *
                                        {32'h00000000, $past(sqrtBus.root)});
  endproperty
  a_flowK: assert property (p_flowK) else $error("fan constant flow wrong");

  property p_rootLatency;
    @(posedge clk) disable iff (!reset_n)
      (s_sampleK ##1 !sampleStrobe [*8]) |=> ##1 sqrtBus.done;
  endproperty
  a_rootLatency: assert property (p_rootLatency) else $error("root not ready in time");

  property p_flowArea;
    @(posedge clk) disable iff (!reset_n)
      (sampleStrobe && flowMode == flow_status_pkg::MODE_AREA) |=>
        flow_q == areaFlow($past(ductArea), velocity_q);
  endproperty
  a_flowArea: assert property (p_flowArea) else $error("area flow wrong");

  property p_velocityHold;
    @(posedge clk) disable iff (!reset_n)
      !velocityEnable |=> $stable(velocity_q);
  endproperty
  a_velocityHold: assert property (p_velocityHold) else $error("velocity moved while off");

  property p_ranges;
    @(posedge clk) disable iff (!reset_n)
      output_q <= flow_status_pkg::OUTPUT_MAX && velocity_q <= flow_status_pkg::VELOCITY_MAX &&
      pressure_q <= flow_status_pkg::PRESSURE_MAX && pressure_q >= flow_status_pkg::PRESSURE_MIN;
  endproperty
  a_ranges: assert property (p_ranges) else $error("register out of range");

  property p_spanSet;
    @(posedge clk) disable iff (!reset_n)
      (!autoTune && (spanP || spanV || spanVel)) |=> spanFlag_q;
  endproperty
  a_spanSet: assert property (p_spanSet) else $error("span flag missed");

  property p_alarmSet;
    @(posedge clk) disable iff (!reset_n)
      (!autoTune && (alarmP || alarmV || alarmVel)) |=> alarmFlag_q;
  endproperty
  a_alarmSet: assert property (p_alarmSet) else $error("alarm flag missed");

  property p_tuneQuiet;
    @(posedge clk) disable iff (!reset_n)
      autoTune [*2] |-> !spanFlag_q && !alarmFlag_q;
  endproperty
  a_tuneQuiet: assert property (p_tuneQuiet) else $error("flag active during tuning");

  property p_faultRead;
    @(posedge clk) disable iff (!reset_n)
      (readStrobe && readAddr == flow_status_pkg::REG_FB_LOST) |=>
        readValid_q && readData_q == {15'h0000, feedbackLost_q};
  endproperty
  a_faultRead: assert property (p_faultRead) else $error("feedback lost read wrong");

  property p_ledDark;
    @(posedge clk) disable iff (!reset_n)
      !faultAny |=> !ledRed_q;
  endproperty
  a_ledDark: assert property (p_ledDark) else $error("indicator lit without fault");

  property p_rsvdZero;
    @(posedge clk) disable iff (!reset_n)
      (readStrobe && rsvdAddr) |=> readValid_q && readData_q == flow_status_pkg::REG_ZERO;
  endproperty
  a_rsvdZero: assert property (p_rsvdZero) else $error("reserved read not zero");

  property p_readPure;
    @(posedge clk) disable iff (!reset_n)
      (readStrobe && !sampleStrobe && !sqrtBus.done) |=>
        $stable(pressure_q) && $stable(flow_q) && $stable(output_q);
  endproperty
  a_readPure: assert property (p_readPure) else $error("read changed a register");
endmodule

// ===== shared/flow_status_pkg.sv
// Constants shared by the pressure and flow status register bank
package flow_status_pkg;

  // Input register indices on the serial register map
  localparam logic [15:0] REG_PRESSURE    = 16'h0001;
  localparam logic [15:0] REG_RSVD_TWO    = 16'h0002;
  localparam logic [15:0] REG_FLOW        = 16'h0003;
  localparam logic [15:0] REG_VELOCITY    = 16'h0004;
  localparam logic [15:0] REG_OUTPUT      = 16'h0005;
  localparam logic [15:0] REG_RSVD_SIX    = 16'h0006;
  localparam logic [15:0] REG_FLOW_MAX    = 16'h0007;
  localparam logic [15:0] REG_SPAN        = 16'h0008;
  localparam logic [15:0] REG_ALARM       = 16'h0009;
  localparam logic [15:0] REG_FB_LOST     = 16'h000A;
  localparam logic [15:0] REG_SENSOR      = 16'h000B;
  localparam logic [15:0] REG_RSVD_FIRST  = 16'h000C;
  localparam logic [15:0] REG_RSVD_LAST   = 16'h0014;

  // Register widths and values
  localparam int          DATA_W          = 16;
  localparam int          ROOT_W          = 8;
  localparam logic [15:0] REG_ZERO        = 16'h0000;
  localparam logic [15:0] FLAG_ON         = 16'h0001;

  // Measurement ranges
  localparam logic signed [15:0] PRESSURE_MAX = 16'sh04E2;
  localparam logic signed [15:0] PRESSURE_MIN = -16'sh04E2;
  localparam logic [15:0] VELOCITY_MAX    = 16'h0096;
  localparam logic [15:0] OUTPUT_MAX      = 16'h03E8;
  localparam logic [15:0] FLOW_SAT        = 16'hFFFF;
  // Whole root of the largest pressure count, floor of sqrt(1250)
  localparam logic [15:0] SQRT_PRESSURE_MAX = 16'h0023;

  // Area mode: m3/h = area(cm2) * velocity(0.1 m/s) * 36 / 1000
  localparam logic [39:0] FLOW_AREA_NUM   = 40'h0000000024;
  localparam logic [39:0] FLOW_AREA_DEN   = 40'h00000003E8;

  // Red indicator flash timing
  localparam int          CLK_HZ          = 100_000_000;
  localparam int          FLASH_HALF_MS   = 250;
  localparam int          FLASH_HALF_CYCLES = (FLASH_HALF_MS * (CLK_HZ / 1000));

  // Flow computation source
  typedef enum logic [1:0] {
    MODE_NONE = 2'b00,
    MODE_K    = 2'b01,
    MODE_AREA = 2'b10
  } flow_mode_t;

  // Square root engine states
  typedef enum logic {
    SQ_IDLE = 1'b0,
    SQ_RUN  = 1'b1
  } sqrt_state_t;

endpackage

// ===== shared/sqrt_if.sv
// Request and answer signals between the bank and its square root engine
`timescale 1ns/1ps
interface sqrt_if;
  logic                                   start;
  logic [flow_status_pkg::DATA_W-1:0]     radicand;
  logic                                   done;
  logic [flow_status_pkg::ROOT_W-1:0]     root;

  modport requester (output start, output radicand, input done, input root);
  modport engine    (input start, input radicand, output done, output root);
endinterface

// ===== design/sqrt_engine.sv
// Bit-serial integer square root, one root bit per cycle
`timescale 1ns/1ps
module sqrt_engine (
  // Clock and reset
  input  wire logic   clk,
  input  wire logic   reset_n,
  // Request and answer
  sqrt_if.engine      bus
);
  flow_status_pkg::sqrt_state_t state_q;
  logic [15:0] rad_q;
  logic [7:0]  root_q;
  logic [2:0]  idx_q;
  logic        done_q;
  logic [7:0]  trial;
  logic [15:0] square;
  logic [17:0] rootSq;
  logic [17:0] nextSq;

  assign trial  = root_q | 8'(8'h01 << idx_q);
  assign square = {8'h00, trial} * {8'h00, trial};
  assign bus.root = root_q;
  assign bus.done = done_q;

  // A new start restarts the engine even mid-run
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q <= flow_status_pkg::SQ_IDLE;
      rad_q   <= 16'h0000;
      root_q  <= 8'h00;
      idx_q   <= 3'h7;
      done_q  <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        flow_status_pkg::SQ_IDLE: begin
          if (bus.start) begin
            rad_q   <= bus.radicand;
            root_q  <= 8'h00;
            idx_q   <= 3'h7;
            state_q <= flow_status_pkg::SQ_RUN;
          end
        end
        flow_status_pkg::SQ_RUN: begin
          if (bus.start) begin
            rad_q  <= bus.radicand;
            root_q <= 8'h00;
            idx_q  <= 3'h7;
          end else begin
            if (square <= rad_q) root_q <= trial;
            idx_q <= idx_q - 3'h1;
            if (idx_q == 3'h0) begin
              state_q <= flow_status_pkg::SQ_IDLE;
              done_q  <= 1'b1;
            end
          end
        end
        default: state_q <= flow_status_pkg::SQ_IDLE;
      endcase
    end
  end

  // Checking helpers
  assign rootSq = {10'h000, root_q} * {10'h000, root_q};
  assign nextSq = ({10'h000, root_q} + 18'h00001) * ({10'h000, root_q} + 18'h00001);

  property p_rootExact;
    @(posedge clk) disable iff (!reset_n)
      done_q |-> (rootSq <= {2'b00, rad_q}) && (nextSq > {2'b00, rad_q});
  endproperty
  a_rootExact: assert property (p_rootExact) else $error("square root result wrong");
endmodule

// ===== design/blink_divider.sv
// Free-running divider giving one enable pulse per flash half period
`timescale 1ns/1ps
module blink_divider #(
  parameter int HALF_CYCLES = flow_status_pkg::FLASH_HALF_CYCLES
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // Half period pulse
  output logic      tick_q
);
  logic [31:0] count_q;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      count_q <= 32'h00000000;
      tick_q  <= 1'b0;
    end else if (count_q == 32'(HALF_CYCLES - 1)) begin
      count_q <= 32'h00000000;
      tick_q  <= 1'b1;
    end else begin
      count_q <= count_q + 32'h00000001;
      tick_q  <= 1'b0;
    end
  end

  property p_tickSingle;
    @(posedge clk) disable iff (!reset_n)
      (tick_q && HALF_CYCLES > 1) |=> !tick_q;
  endproperty
  a_tickSingle: assert property (p_tickSingle) else $error("flash tick longer than a cycle");
endmodule

// ===== sim/modbus_master_model.sv
// Serial master stand-in issuing single-word register reads
`timescale 1ns/1ps
module modbus_master_model (
  // Clock
  input  wire logic        clk,
  // Read request and answer
  output logic             readStrobe,
  output logic [15:0]      readAddr,
  input  wire logic [15:0] readData_q,
  input  wire logic        readValid_q
);
  initial begin
    readStrobe = 1'b0;
    readAddr   = 16'h0;
  end

  // One word per request, never a write
  task automatic readWord(input logic [15:0] addr, output logic [15:0] data, output logic ok);
    ok = 1'b0;
    data = 16'h0;
    @(posedge clk);
    readStrobe <= 1'b1;
    readAddr   <= addr;
    @(posedge clk);
    readStrobe <= 1'b0;
    // Released address lines do not keep the last value
    readAddr   <= ~addr;
    for (int i = 0; i < 4 && !ok; i++) begin
      @(posedge clk);
      if (readValid_q === 1'b1) begin
        ok = 1'b1;
        data = readData_q;
      end
    end
  endtask
endmodule

// ===== sim/tb.sv
// Self-checking bench for the status input register bank
`timescale 1ns/1ps
module tb;
  typedef struct {
    logic [15:0] p, v, o, k, a;
    logic        ven;
    logic [15:0] addr, exp;
  } row_t;
  logic               clk = 1'b0, reset_n = 1'b0, sampleStrobe = 1'b0, velocityEnable = 1'b0;
  logic               autoTune = 1'b0, feedbackLostIn = 1'b0, sensorFaultIn = 1'b0;
  logic signed [15:0] pressureIn = 16'sh64;
  logic [15:0]        velocityIn = 16'h0, outputIn = 16'h0, fanConstant = 16'h0;
  logic [15:0]        ductArea = 16'h0;
  logic signed [15:0] spanPressMin = 16'shFB1E, spanPressMax = 16'sh4E2;
  logic signed [15:0] alarmPressMin = 16'shFB1E, alarmPressMax = 16'sh4E2;
  logic [15:0]        spanVolMin = 16'h0, spanVolMax = 16'hFFFF, spanVelMin = 16'h0;
  logic [15:0]        spanVelMax = 16'hFFFF, alarmVolMin = 16'h0, alarmVolMax = 16'hFFFF;
  logic [15:0]        alarmVelMin = 16'h0, alarmVelMax = 16'hFFFF, readAddr, readData_q;
  logic               readStrobe, readValid_q, ledRed_q, lastLed;
  int                 failCount = 0, cmpCount = 0, toggles;
  row_t               rows [18];

  always #5 clk = ~clk;

  pressure_flow_status_inputs #(.FLASH_HALF_CYCLES(4)) pressure_flow_status_inputs_i (
    .clk, .reset_n, .sampleStrobe, .pressureIn, .velocityIn, .outputIn, .fanConstant,
    .ductArea, .velocityEnable, .spanPressMin, .spanPressMax, .spanVolMin, .spanVolMax,
    .spanVelMin, .spanVelMax, .alarmPressMin, .alarmPressMax, .alarmVolMin, .alarmVolMax,
    .alarmVelMin, .alarmVelMax, .autoTune, .feedbackLostIn, .sensorFaultIn, .readStrobe,
    .readAddr, .readData_q, .readValid_q, .ledRed_q);

  modbus_master_model modbus_master_model_i (
    .clk, .readStrobe, .readAddr, .readData_q, .readValid_q);

  task automatic testDone();
    if (failCount == 0 && cmpCount > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      failCount++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic readCheck(input string name, input logic [15:0] addr, input logic [15:0] exp);
    logic [15:0] d;
    logic        ok;
    modbus_master_model_i.readWord(addr, d, ok);
    if (ok !== 1'b1) begin
      failCount++;
      testDone();
    end else begin
      check(name, d, exp);
    end
  endtask

  // Strobe one sample set and let the root run finish
  task automatic sample();
    sampleStrobe <= 1'b1;
    @(posedge clk);
    sampleStrobe <= 1'b0;
    repeat (14) @(posedge clk);
  endtask

  initial begin
    rows = '{
      '{16'h64, 16'h0, 16'h0, 16'hA, 16'h0, 1'b0, 16'h3, 16'h64},
      '{16'h64, 16'h0, 16'h0, 16'hA, 16'h0, 1'b0, 16'h1, 16'h64},
      '{16'h7D0, 16'h0, 16'h0, 16'hA, 16'h0, 1'b0, 16'h1, 16'h4E2},
      '{16'hF830, 16'h0, 16'h0, 16'hA, 16'h0, 1'b0, 16'h1, 16'hFB1E},
      '{16'hFF9C, 16'h0, 16'h0, 16'hA, 16'h0, 1'b0, 16'h3, 16'h0},
      '{16'h64, 16'h0, 16'h0, 16'hA, 16'h0, 1'b0, 16'h7, 16'h15E},
      '{16'h64, 16'hC8, 16'h0, 16'hA, 16'h0, 1'b1, 16'h4, 16'h96},
      '{16'h64, 16'h32, 16'h0, 16'hA, 16'h0, 1'b0, 16'h4, 16'h96},
      '{16'h64, 16'h0, 16'h5DC, 16'hA, 16'h0, 1'b0, 16'h5, 16'h3E8},
      '{16'h64, 16'h0, 16'h3E7, 16'hA, 16'h0, 1'b0, 16'h5, 16'h3E7},
      '{16'h64, 16'h64, 16'h0, 16'h0, 16'h3E8, 1'b1, 16'h3, 16'hE10},
      '{16'h64, 16'h64, 16'h0, 16'h0, 16'h3E8, 1'b1, 16'h7, 16'h1518},
      '{16'h64, 16'h0, 16'h0, 16'h0, 16'h3E8, 1'b0, 16'h3, 16'h0},
      '{16'h64, 16'h0, 16'h0, 16'h0, 16'h3E8, 1'b0, 16'h7, 16'h0},
      '{16'h64, 16'h0, 16'h0, 16'hA, 16'h0, 1'b0, 16'h2, 16'h0},
      '{16'h64, 16'h0, 16'h0, 16'hA, 16'h0, 1'b0, 16'h6, 16'h0},
      '{16'h64, 16'h0, 16'h0, 16'hA, 16'h0, 1'b0, 16'h14, 16'h0},
      '{16'h64, 16'h0, 16'h0, 16'hA, 16'h0, 1'b0, 16'h15, 16'h0}};
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    readCheck("pressureAfterReset", 16'h1, 16'h0);
    foreach (rows[i]) begin
      pressureIn     <= rows[i].p;
      velocityIn     <= rows[i].v;
      outputIn       <= rows[i].o;
      fanConstant    <= rows[i].k;
      ductArea       <= rows[i].a;
      velocityEnable <= rows[i].ven;
      sample();
      readCheck("row", rows[i].addr, rows[i].exp);
    end
    // Velocity span counts only while velocity is measured
    spanVelMax <= 16'h32;
    repeat (3) @(posedge clk);
    readCheck("spanVelOff", 16'h8, 16'h0);
    velocityEnable <= 1'b1;
    repeat (3) @(posedge clk);
    readCheck("spanVel", 16'h8, 16'h1);
    velocityEnable <= 1'b0;
    // Pressure above its span only, then flow above its alarm limit
    spanPressMax <= 16'sh32;
    sample();
    readCheck("span", 16'h8, 16'h1);
    readCheck("alarm", 16'h9, 16'h0);
    alarmVolMax <= 16'h32;
    repeat (3) @(posedge clk);
    readCheck("alarm", 16'h9, 16'h1);
    autoTune <= 1'b1;
    repeat (3) @(posedge clk);
    readCheck("spanTuning", 16'h8, 16'h0);
    readCheck("alarmTuning", 16'h9, 16'h0);
    autoTune <= 1'b0;
    feedbackLostIn <= 1'b1;
    repeat (3) @(posedge clk);
    readCheck("fbLost", 16'hA, 16'h1);
    toggles = 0;
    lastLed = ledRed_q;
    repeat (16) begin
      @(posedge clk);
      if (ledRed_q !== lastLed) toggles++;
      lastLed = ledRed_q;
    end
    check("ledFlash", 16'(toggles), 16'h4);
    feedbackLostIn <= 1'b0;
    sensorFaultIn <= 1'b1;
    repeat (3) @(posedge clk);
    readCheck("sensorFault", 16'hB, 16'h1);
    readCheck("fbClear", 16'hA, 16'h0);
    sensorFaultIn <= 1'b0;
    repeat (3) @(posedge clk);
    readCheck("sensorClear", 16'hB, 16'h0);
    check("ledOff", 16'(ledRed_q), 16'h0);
    // Reset in mid-run clears the captured values
    reset_n <= 1'b0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    readCheck("pressureReset", 16'h1, 16'h0);
    readCheck("flowReset", 16'h3, 16'h0);
    testDone();
  end
endmodule
